/* File: design/xlate_pkg.sv */
package xlate_pkg;
  // address widths
  localparam int AXI_AW = 48;
  localparam int LNK_AW = 64;
  localparam int NWIN   = 6;
  // apb register byte offsets
  localparam logic [11:0] VEC_BASE_OFS = 12'h000; // lo at +0, hi at +4
  localparam logic [11:0] STATUS_OFS   = 12'h040; // sticky events, w1c
  localparam logic [11:0] MASK_OFS     = 12'h044; // event enables
  localparam logic [11:0] STATE_OFS    = 12'h048; // live bridge state
  // reset values
  localparam logic [31:0] VEC_RST      = 32'h0000_0000;
  localparam logic [2:0]  MASK_RST     = 3'h0;
  // event bit positions
  localparam int EV_SLVERR = 0; // outgoing access outside all windows
  localparam int EV_BADVEC = 1; // vector bits set below aperture
  localparam int EV_INMISS = 2; // inbound request hit no window
  // size code to aperture exponent: code 8 is 32 kbyte
  localparam int SIZE_EXP_OFS = 7;
  // outstanding inbound write counter limit
  localparam logic [3:0] WR_CNT_MAX = 4'hF;
  // default window layout: 64 kbyte windows stacked from zero
  localparam logic [NWIN*64-1:0] BASE_DEF = {
    64'h0000_0000_0005_0000, 64'h0000_0000_0004_0000,
    64'h0000_0000_0003_0000, 64'h0000_0000_0002_0000,
    64'h0000_0000_0001_0000, 64'h0000_0000_0000_0000};
  localparam logic [NWIN*64-1:0] HIGH_DEF = {
    64'h0000_0000_0005_FFFF, 64'h0000_0000_0004_FFFF,
    64'h0000_0000_0003_FFFF, 64'h0000_0000_0002_FFFF,
    64'h0000_0000_0001_FFFF, 64'h0000_0000_0000_FFFF};
  // outgoing and inbound state machines
  typedef enum logic [2:0] {O_IDLE, O_DEC, O_SEND, O_COMMIT, O_CPL,
                            O_RESP} out_state_t;
  typedef enum logic [2:0] {I_IDLE, I_DEC, I_HOLD, I_ISSUE} in_state_t;
  // vector upper bits over aperture, offset in the low bits
  function automatic logic [63:0] apply_xlate(input logic [63:0] vec,
                                              input logic [63:0] msk,
                                              input logic [63:0] ofs);
    apply_xlate = (vec & ~msk) | (ofs & msk);
  endfunction
endpackage

/* File: design/win_dec_if.sv */
`timescale 1ns/1ps
interface win_dec_if;
  logic [63:0] req_addr; // address to decode
  logic [2:0]  sel;      // window picked by the link, inbound only
  logic        hit;      // address lies in a window
  logic [2:0]  idx;      // index of the hit window
  logic [63:0] offset;   // address relative to window start
  logic [63:0] msk;      // aperture mask, size minus one
  modport requester (output req_addr, sel, input hit, idx, offset, msk);
  modport decoder (input req_addr, sel, output hit, idx, offset, msk);
endinterface

/* File: design/axi_window_decode.sv */
`timescale 1ns/1ps
module axi_window_decode #(
  parameter int                             axi_window_count = 6,
  parameter logic [xlate_pkg::NWIN*64-1:0] axi_window_base = '0,
  parameter logic [xlate_pkg::NWIN*64-1:0] axi_window_high = '0
) (
  win_dec_if.decoder d
);
  // first window whose base..high range holds the address
  always_comb begin
    logic [63:0] b;
    logic [63:0] h;
    b = '0;
    h = '0;
    d.hit    = 1'b0;
    d.idx    = 3'h0;
    d.offset = '0;
    d.msk    = '0;
    for (int i = xlate_pkg::NWIN - 1; i >= 0; i--) begin
      b = axi_window_base[i*64 +: 64];
      h = axi_window_high[i*64 +: 64];
      if (i < axi_window_count && d.req_addr >= b && d.req_addr <= h) begin
        d.hit    = 1'b1;
        d.idx    = 3'(i);
        d.offset = d.req_addr - b; // base is offset zero
        d.msk    = h - b;
      end
    end
  end
endmodule

/* File: design/link_window_decode.sv */
`timescale 1ns/1ps
module link_window_decode #(
  parameter int                            link_window_count     = 6,
  parameter logic [xlate_pkg::NWIN*8-1:0] link_window_size_code = '0,
  parameter logic [xlate_pkg::NWIN-1:0]   link_window_is64      = '0
) (
  win_dec_if.decoder d
);
  // window picked by the link; odd partner of a 64-bit pair is off
  always_comb begin
    logic [7:0] code;
    code     = link_window_size_code[d.sel*8 +: 8];
    d.idx    = d.sel;
    d.hit    = (32'(d.sel) < 32'(link_window_count)) &&
               !(d.sel[0] && link_window_is64[d.sel - 3'h1]);
    d.msk    = (64'h1 << (32'(code) + xlate_pkg::SIZE_EXP_OFS)) - 64'h1;
    d.offset = d.req_addr & d.msk;
  end
endmodule

/* File: design/axi_pcie_ordering_xlate.sv */
`timescale 1ns/1ps
module axi_pcie_ordering_xlate #(
  parameter int                            axi_window_count  = 6,
  parameter logic [xlate_pkg::NWIN*64-1:0] axi_window_base   =
    xlate_pkg::BASE_DEF,
  parameter logic [xlate_pkg::NWIN*64-1:0] axi_window_high   =
    xlate_pkg::HIGH_DEF,
  parameter int                            link_window_count = 6,
  parameter logic [xlate_pkg::NWIN*8-1:0]  link_window_size_code = '0,
  parameter logic [xlate_pkg::NWIN-1:0]    link_window_is64  = '0,
  parameter logic [xlate_pkg::NWIN*64-1:0] link_to_axi_xlate_vector = '0
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // outgoing request from axi master
  input  wire logic        out_req_valid,
  input  wire logic        out_req_write,
  input  wire logic [47:0] out_req_addr,
  output logic             out_req_ack,
  output logic             out_rsp_valid,
  output logic             out_rsp_err,
  output logic      [31:0] out_rsp_data,
  input  wire logic        out_rsp_ready,
  // link transmit side
  output logic             tx_valid,
  output logic             tx_write,
  output logic             tx_4dw,
  output logic      [63:0] tx_addr,
  input  wire logic        tx_ready,
  input  wire logic        tx_commit,
  // completions from link
  input  wire logic        cpl_valid,
  input  wire logic [31:0] cpl_data,
  output logic             cpl_ack,
  // inbound request from link
  input  wire logic        in_valid,
  input  wire logic        in_write,
  input  wire logic        in_ro,
  input  wire logic [2:0]  in_bar,
  input  wire logic [63:0] in_addr,
  output logic             in_ack,
  // axi master toward local slaves
  output logic             m_valid,
  output logic             m_write,
  output logic      [47:0] m_addr,
  input  wire logic        m_ready,
  input  wire logic        m_bresp,
  // interrupt
  output logic             irq
);
  // whole state of the bridge
  typedef struct packed {
    xlate_pkg::out_state_t o_st;     // outgoing machine
    logic                  o_write;  // captured direction
    logic [63:0]           o_addr;   // captured axi address
    logic                  req_ack;  // request taken pulse
    logic                  tx_valid; // link request pending
    logic                  tx_write;
    logic                  tx_4dw;
    logic [63:0]           tx_addr;
    logic                  rsp_valid;
    logic                  rsp_err;
    logic [31:0]           rsp_data;
    logic                  cpl_ack;
    xlate_pkg::in_state_t  i_st;     // inbound machine
    logic                  i_write;
    logic                  i_ro;
    logic [2:0]            i_bar;
    logic [63:0]           i_addr;
    logic                  in_ack;
    logic                  m_valid;
    logic                  m_write;
    logic [47:0]           m_addr;
    logic [3:0]            wr_cnt;   // inbound writes awaiting bresp
    logic [11:0][31:0]     vec;      // axi to link vectors, lo/hi
    logic [2:0]            status;   // sticky events
    logic [2:0]            mask;     // event enables
    logic                  irq;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
  } state_t;

  state_t st_reg;  // registered state
  state_t st_next; // next state

  // decoder links
  win_dec_if out_dec ();
  win_dec_if in_dec ();

  axi_window_decode #(
    .axi_window_count (axi_window_count),
    .axi_window_base  (axi_window_base),
    .axi_window_high  (axi_window_high)
  ) u_out_dec (
    .d (out_dec)
  );

  link_window_decode #(
    .link_window_count     (link_window_count),
    .link_window_size_code (link_window_size_code),
    .link_window_is64      (link_window_is64)
  ) u_in_dec (
    .d (in_dec)
  );

  // decoders look at captured addresses only
  assign out_dec.req_addr = st_reg.o_addr;
  assign out_dec.sel      = 3'h0;
  assign in_dec.req_addr  = st_reg.i_addr;
  assign in_dec.sel       = st_reg.i_bar;

  // next-state logic
  always_comb begin
    logic [63:0] vec;     // vector of the hit axi window
    logic [63:0] xl;      // translated address
    logic [2:0]  ev;      // events this cycle
    logic        wr_inc;  // inbound write issued
    logic        acc;     // apb access phase
    logic [3:0]  ridx;    // register index for vectors
    vec    = {st_reg.vec[{out_dec.idx, 1'b1}],
              st_reg.vec[{out_dec.idx, 1'b0}]};
    xl     = '0;
    ev     = 3'h0;
    wr_inc = 1'b0;
    acc    = psel && penable && st_reg.pready;
    ridx   = paddr[6:3];
    st_next         = st_reg;
    st_next.req_ack = 1'b0;
    st_next.cpl_ack = 1'b0;
    st_next.in_ack  = 1'b0;

    // outgoing machine: axi master to link
    case (st_reg.o_st)
      xlate_pkg::O_IDLE: begin
        if (out_req_valid) begin
          st_next.o_write = out_req_write;
          st_next.o_addr  = {16'h0000, out_req_addr};
          st_next.req_ack = 1'b1;
          st_next.o_st    = xlate_pkg::O_DEC;
        end
      end
      xlate_pkg::O_DEC: begin
        if (!out_dec.hit) begin
          // outside every window: answer locally
          st_next.rsp_valid = 1'b1;
          st_next.rsp_err   = 1'b1;
          st_next.rsp_data  = '0;
          ev[xlate_pkg::EV_SLVERR] = 1'b1;
          st_next.o_st      = xlate_pkg::O_RESP;
        end else begin
          // vector over aperture, offset below
          xl = xlate_pkg::apply_xlate(vec, out_dec.msk, out_dec.offset);
          ev[xlate_pkg::EV_BADVEC] = |(vec & out_dec.msk);
          st_next.tx_addr  = xl;
          st_next.tx_4dw   = |vec[63:32];
          st_next.tx_write = st_reg.o_write;
          st_next.tx_valid = 1'b1;
          st_next.o_st     = xlate_pkg::O_SEND;
        end
      end
      xlate_pkg::O_SEND: begin
        if (tx_ready) begin
          st_next.tx_valid = 1'b0;
          st_next.o_st     = st_reg.tx_write ? xlate_pkg::O_COMMIT
                                             : xlate_pkg::O_CPL;
        end
      end
      xlate_pkg::O_COMMIT: begin
        // response only once the write is ordered on the link
        if (tx_commit) begin
          st_next.rsp_valid = 1'b1;
          st_next.rsp_err   = 1'b0;
          st_next.rsp_data  = '0;
          st_next.o_st      = xlate_pkg::O_RESP;
        end
      end
      xlate_pkg::O_CPL: begin
        // completion waits for inbound bresps
        if (cpl_valid && st_reg.wr_cnt == 4'h0) begin
          st_next.cpl_ack   = 1'b1;
          st_next.rsp_valid = 1'b1;
          st_next.rsp_err   = 1'b0;
          st_next.rsp_data  = cpl_data;
          st_next.o_st      = xlate_pkg::O_RESP;
        end
      end
      xlate_pkg::O_RESP: begin
        if (out_rsp_ready) begin
          st_next.rsp_valid = 1'b0;
          st_next.o_st      = xlate_pkg::O_IDLE;
        end
      end
      default: begin
        st_next.o_st = xlate_pkg::O_IDLE;
      end
    endcase

    // inbound machine: link to axi slaves
    case (st_reg.i_st)
      xlate_pkg::I_IDLE: begin
        if (in_valid) begin
          st_next.i_write = in_write;
          st_next.i_ro    = in_ro;
          st_next.i_bar   = in_bar;
          st_next.i_addr  = in_addr;
          st_next.in_ack  = 1'b1;
          st_next.i_st    = xlate_pkg::I_DEC;
        end
      end
      xlate_pkg::I_DEC: begin
        if (!in_dec.hit) begin
          // no window: drop and flag
          ev[xlate_pkg::EV_INMISS] = 1'b1;
          st_next.i_st = xlate_pkg::I_IDLE;
        end else begin
          // vector bits replace those above the aperture
          xl = xlate_pkg::apply_xlate(
                 link_to_axi_xlate_vector[in_dec.idx*64 +: 64],
                 in_dec.msk, in_dec.offset);
          st_next.m_addr  = xl[47:0];
          st_next.m_write = st_reg.i_write;
          st_next.i_st    = xlate_pkg::I_HOLD;
        end
      end
      xlate_pkg::I_HOLD: begin
        // strict reads wait for zero pending writes
        // relaxed reads go at once
        if (st_reg.i_write ? st_reg.wr_cnt != xlate_pkg::WR_CNT_MAX
                           : st_reg.i_ro || st_reg.wr_cnt == 4'h0) begin
          st_next.m_valid = 1'b1;
          st_next.i_st    = xlate_pkg::I_ISSUE;
        end
      end
      xlate_pkg::I_ISSUE: begin
        if (m_ready) begin
          st_next.m_valid = 1'b0;
          wr_inc          = st_reg.m_write;
          st_next.i_st    = xlate_pkg::I_IDLE;
        end
      end
      default: begin
        st_next.i_st = xlate_pkg::I_IDLE;
      end
    endcase

    // count inbound writes still awaiting their response
    if (wr_inc && !m_bresp) begin
      st_next.wr_cnt = st_reg.wr_cnt + 4'h1;
    end else if (!wr_inc && m_bresp && st_reg.wr_cnt != 4'h0) begin
      st_next.wr_cnt = st_reg.wr_cnt - 4'h1;
    end

    // apb: ready one cycle after setup, read data staged at setup
    st_next.pready  = psel && !penable;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      st_next.prdata = '0;
      if (paddr < 12'(8 * xlate_pkg::NWIN) && paddr[1:0] == 2'b00) begin
        st_next.prdata = st_reg.vec[{ridx[2:0], paddr[2]}];
      end else if (paddr == xlate_pkg::STATUS_OFS) begin
        st_next.prdata = {29'h0, st_reg.status};
      end else if (paddr == xlate_pkg::MASK_OFS) begin
        st_next.prdata = {29'h0, st_reg.mask};
      end else if (paddr == xlate_pkg::STATE_OFS) begin
        st_next.prdata = {21'h0, st_reg.wr_cnt, 1'b0, st_reg.i_st,
                          st_reg.o_st};
      end else begin
        st_next.pslverr = 1'b1; // unmapped
      end
    end
    if (acc) begin
      st_next.pslverr = 1'b0;
      st_next.pready  = 1'b0;
    end
    // software rewrites vectors, used by later accesses
    if (acc && pwrite) begin
      if (paddr < 12'(8 * xlate_pkg::NWIN) && paddr[1:0] == 2'b00) begin
        st_next.vec[{ridx[2:0], paddr[2]}] = pwdata;
      end else if (paddr == xlate_pkg::STATUS_OFS) begin
        st_next.status = st_reg.status & ~pwdata[2:0];
      end else if (paddr == xlate_pkg::MASK_OFS) begin
        st_next.mask = pwdata[2:0];
      end
    end
    // events set after the clear, so a same-cycle event wins
    st_next.status = st_next.status | ev;
    st_next.irq    = |(st_next.status & st_next.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.o_st   <= xlate_pkg::O_IDLE;
      st_reg.i_st   <= xlate_pkg::I_IDLE;
      st_reg.vec    <= {12{xlate_pkg::VEC_RST}};
      st_reg.mask   <= xlate_pkg::MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign out_req_ack = st_reg.req_ack;
  assign out_rsp_valid = st_reg.rsp_valid;
  assign out_rsp_err = st_reg.rsp_err;
  assign out_rsp_data = st_reg.rsp_data;
  assign tx_valid = st_reg.tx_valid;
  assign tx_write = st_reg.tx_write;
  assign tx_4dw = st_reg.tx_4dw;
  assign tx_addr = st_reg.tx_addr;
  assign cpl_ack = st_reg.cpl_ack;
  assign in_ack = st_reg.in_ack;
  assign m_valid = st_reg.m_valid;
  assign m_write = st_reg.m_write;
  assign m_addr = st_reg.m_addr;
  assign irq = st_reg.irq;
endmodule

/* File: verification/axi_pcie_ordering_xlate_asserts.sv */
`timescale 1ns/1ps
module axi_pcie_ordering_xlate_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // register port
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // outgoing side
  input wire logic        out_req_write,
  input wire logic [47:0] out_req_addr,
  input wire logic        out_req_ack,
  input wire logic        out_rsp_valid,
  input wire logic        out_rsp_err,
  input wire logic        tx_valid,
  input wire logic        tx_4dw,
  input wire logic [63:0] tx_addr,
  input wire logic        tx_ready,
  input wire logic        tx_commit,
  input wire logic        cpl_ack,
  // inbound side
  input wire logic        in_ro,
  input wire logic        in_ack,
  input wire logic        m_valid,
  input wire logic        m_write,
  input wire logic [47:0] m_addr,
  input wire logic        m_ready,
  input wire logic        m_bresp
);
  // first byte above the six default windows
  localparam logic [47:0] MISS_LO = 48'h0000_0006_0000;
  logic       wr_q;   // current outgoing is a write
  logic       cmt_q;  // commit seen for it
  logic       ro_q;   // current inbound is relaxed
  logic [4:0] pend_q; // inbound writes still unanswered
  // track the request kinds and the write balance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q   <= 1'b0;
      cmt_q  <= 1'b0;
      ro_q   <= 1'b0;
      pend_q <= 5'h0;
    end else begin
      if (out_req_ack) wr_q <= out_req_write;
      cmt_q  <= out_req_ack ? 1'b0 : (cmt_q | tx_commit);
      if (in_ack) ro_q <= in_ro;
      pend_q <= pend_q + 5'(m_valid && m_ready && m_write) - 5'(m_bresp);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a request taken inside or outside every window
  sequence s_take_miss;
    out_req_ack && out_req_addr >= MISS_LO;
  endsequence
  sequence s_take_hit;
    out_req_ack && out_req_addr < MISS_LO;
  endsequence
  a_miss_slverr: assert property (s_take_miss |-> ##[1:3] out_rsp_valid && out_rsp_err) else $error("no slverr");
  a_miss_no_tx: assert property (s_take_miss |-> (!tx_valid) [*4]) else $error("miss sent");
  a_hit_send: assert property (s_take_hit |-> ##[1:3] tx_valid) else $error("hit lost");
  a_wr_commit: assert property (out_rsp_valid && wr_q && !out_rsp_err |-> cmt_q) else $error("early bresp");
  a_hdr_size: assert property (tx_valid |-> tx_4dw == (tx_addr[63:32] != 32'h0)) else $error("hdr size");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_addr)) else $error("tx dropped");
  a_strict_wait: assert property ($rose(m_valid) && !m_write && !ro_q |-> pend_q == 5'h0) else $error("read passed");
  a_cpl_wait: assert property (cpl_ack |-> $past(pend_q) == 5'h0) else $error("cpl passed");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb timing");
  a_m_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_addr)) else $error("m dropped");
endmodule
bind axi_pcie_ordering_xlate axi_pcie_ordering_xlate_asserts chk (.*);

/* File: verification/xlate_partner.sv */
`timescale 1ns/1ps
module xlate_partner (
  // clock and bench control
  input  wire logic        pclk,
  input  wire logic        hold_bresp,
  // link transmit and completions
  input  wire logic        tx_valid,
  input  wire logic        tx_write,
  input  wire logic [63:0] tx_addr,
  output logic             tx_ready,
  output logic             tx_commit,
  output logic             cpl_valid,
  output logic      [31:0] cpl_data,
  input  wire logic        cpl_ack,
  // local slave
  input  wire logic        m_valid,
  input  wire logic        m_write,
  output logic             m_ready,
  output logic             m_bresp
);
  integer      seed = 32'h1357_9bdf; // own stream of delays
  int          nb   = 0;             // write responses owed
  // link: accept after 0-2 cycles, then commit or complete
  initial begin
    tx_ready  = 1'b0;
    tx_commit = 1'b0;
    cpl_valid = 1'b0;
    cpl_data  = 32'h0;
    forever begin
      @(posedge pclk);
      cpl_data <= $random(seed);
      if (tx_valid) begin
        repeat ($unsigned($random(seed)) % 3) @(posedge pclk);
        tx_ready <= 1'b1;
        @(posedge pclk);
        tx_ready <= 1'b0;
        if (tx_write) begin
          tx_commit <= 1'b1; // write now ordered on the link
          @(posedge pclk);
          tx_commit <= 1'b0;
        end else begin
          cpl_valid <= 1'b1;
          cpl_data  <= ~tx_addr[31:0];
          do @(posedge pclk); while (cpl_ack !== 1'b1);
          cpl_valid <= 1'b0;
        end
      end
    end
  end
  // local slave: accept after 0-2 cycles
  initial begin
    m_ready = 1'b0;
    forever begin
      @(posedge pclk);
      if (m_valid) begin
        repeat ($unsigned($random(seed)) % 3) @(posedge pclk);
        m_ready <= 1'b1;
        @(posedge pclk);
        m_ready <= 1'b0;
      end
    end
  end
  // one write response per accepted write, paused by the bench
  initial m_bresp = 1'b0;
  always @(posedge pclk) begin
    if (m_valid && m_ready && m_write)
      nb = nb + 1;
    if (nb > 0 && !hold_bresp && !m_bresp) begin
      m_bresp <= 1'b1;
      nb = nb - 1;
    end else
      m_bresp <= 1'b0;
  end
endmodule

/* File: verification/axi_pcie_ordering_xlate_tb.sv */
`timescale 1ns/1ps
module axi_pcie_ordering_xlate_tb;
  // inbound windows: 0 is 64-bit 32 kbyte, 2 is 32-bit 4 kbyte
  localparam logic [63:0] LV0 = 64'h0000_0000_1234_0000;
  localparam logic [63:0] LV2 = 64'h0000_00AB_CDEF_0000;
  localparam logic [11:0] ST  = xlate_pkg::STATUS_OFS;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cpl_data, rd_v;
  logic out_req_valid, out_req_write, out_req_ack, out_rsp_valid;
  logic out_rsp_err, out_rsp_ready, tx_valid, tx_write, tx_4dw, tx_ready;
  logic tx_commit, cpl_valid, cpl_ack, in_valid, in_write, in_ro, in_ack;
  logic m_valid, m_write, m_ready, m_bresp, irq, hold_bresp, rd_e;
  logic [47:0] out_req_addr, m_addr;
  logic [31:0] out_rsp_data;
  logic [63:0] tx_addr, in_addr;
  logic [2:0]  in_bar;
  integer      seed = 32'h38c6_2623;
  int          err_count = 0, n_checks = 0, cyc = 0;
  logic [63:0] vec [6];   // bench copy of outgoing vectors
  logic [65:0] q_tx [$];  // write, 4dw, link address
  logic [33:0] q_rsp [$]; // error, is read, data
  logic [48:0] q_m [$];   // write, local address
  always #2.5 pclk = ~pclk;
  axi_pcie_ordering_xlate #(.link_window_count(3),
    .link_window_size_code({24'h0, 8'h05, 8'h00, 8'h08}),
    .link_window_is64(6'h01),
    .link_to_axi_xlate_vector({192'h0, LV2, 64'h0, LV0})) dut (.*);
  xlate_partner far (.*);
  // vector bits above the aperture, address bits below it
  function automatic logic [63:0] mx(input logic [63:0] v, a, input int k);
    logic [63:0] m;
    m = (64'h1 << k) - 64'h1;
    return (v & ~m) | (a & m);
  endfunction
  // count a comparison, report a mismatch
  task automatic note(input logic ok, input string what);
    n_checks++;
    if (!ok) begin
      err_count++;
      $display("Error at %0t: bad %s", $time, what);
    end
  endtask
  task automatic cmp_tx(input logic [65:0] g);
    note(g === (q_tx.size() != 0 ? q_tx.pop_front() : 'x), "tx");
  endtask
  task automatic cmp_m(input logic [48:0] g);
    note(g === (q_m.size() != 0 ? q_m.pop_front() : 'x), "m req");
  endtask
  task automatic cmp_rsp(input logic [32:0] g);
    logic [33:0] e;
    e = q_rsp.size() != 0 ? q_rsp.pop_front() : 'x;
    note(g[32] === e[33] && (!e[32] || g[31:0] === e[31:0]), "rsp");
  endtask
  task automatic cmp_reg(input logic [31:0] g, e);
    note(g === e, "reg");
  endtask
  // one register transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp_reg(rd_v, e);
  endtask
  task automatic setv(input int n, input logic [63:0] v);
    apb(1'b1, 12'(8 * n), v[31:0]);
    apb(1'b1, 12'(8 * n + 4), v[63:32]);
    vec[n] = v;
  endtask
  // outgoing request and its expected results
  task automatic out_op(input logic w, input logic [47:0] a);
    logic [63:0] t;
    t = mx(vec[a[18:16]], {16'h0, a}, 16);
    if (a >= 48'h0000_0006_0000) q_rsp.push_back({2'b10, 32'h0});
    else begin
      q_tx.push_back({w, t[63:32] != 32'h0, t});
      q_rsp.push_back({1'b0, !w, ~t[31:0]});
    end
    out_req_valid <= 1'b1;
    out_req_write <= w;
    out_req_addr <= a;
    do @(posedge pclk); while (out_req_ack !== 1'b1);
    out_req_valid <= 1'b0;
    do @(posedge pclk); while (!(out_rsp_valid && out_rsp_ready));
  endtask
  task automatic in_op(input logic w, ro, input logic [2:0] b,
                       input logic [63:0] a, input int k);
    logic [63:0] t;
    if (k != 0) begin
      t = mx(b[1] ? LV2 : LV0, a, k);
      q_m.push_back({w, t[47:0]});
    end
    in_valid <= 1'b1;
    in_write <= w;
    in_ro <= ro;
    in_bar <= b;
    in_addr <= a;
    do @(posedge pclk); while (in_ack !== 1'b1);
    in_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // bounded wait for all noted results
  task automatic drain;
    for (int i = 0; i < 300 && q_m.size() + q_tx.size() + q_rsp.size() != 0;
         i++) @(posedge pclk);
    note(q_m.size() + q_tx.size() + q_rsp.size() == 0, "count");
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // results compared in order of appearance
  always @(posedge pclk) begin
    if (tx_valid && tx_ready)
      cmp_tx({tx_write, tx_4dw, tx_addr});
    if (out_rsp_valid && out_rsp_ready)
      cmp_rsp({out_rsp_err, out_rsp_data});
    if (m_valid && m_ready)
      cmp_m({m_write, m_addr});
    out_rsp_ready <= 1'($random(seed));
    if (++cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hold_bresp} = '0;
    {out_req_valid, out_req_write, out_req_addr, out_rsp_ready} = '0;
    {in_valid, in_write, in_ro, in_bar, in_addr} = '0;
    vec = '{default: '0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h0);
    rd(xlate_pkg::MASK_OFS, 32'(xlate_pkg::MASK_RST));
    apb(1'b1, 12'h100, 32'h1);
    cmp_reg(32'(rd_e), 32'h1);
    rd(ST, 32'h0);
    // every window, random vectors of both header sizes
    for (int n = 0; n < 6; n++) begin
      setv(n, {n[0] ? 32'($random(seed)) : 32'h0,
               32'($random(seed)) & 32'hFFFF_0000});
      out_op(1'b1, {29'h0, n[2:0], 16'($random(seed)) & 16'hFFFC});
      out_op(1'b0, {29'h0, n[2:0], 16'($random(seed)) & 16'hFFFC});
    end
    // window edges, misses and a vector with low bits set
    out_op(1'b1, 48'h0000_0005_FFFF);
    out_op(1'b0, 48'h0000_0000_0000);
    out_op(1'b1, 48'h0000_0006_0000);
    out_op(1'b0, 48'hFFFF_FFFF_FFFF);
    setv(3, 64'h0000_0000_5671_0ABC);
    out_op(1'b0, 48'h0000_0003_1234);
    drain();
    rd(ST, 32'h3);
    // inbound ordering while write responses are held back
    hold_bresp <= 1'b1;
    in_op(1'b1, 1'b0, 3'h0, 64'h0000_0020_ABCD_FFF4, 15);
    in_op(1'b0, 1'b1, 3'h2, 64'h0000_0000_0000_0123, 12);
    drain();
    in_op(1'b0, 1'b0, 3'h0, 64'h0000_0000_0000_7008, 15);
    fork
      out_op(1'b0, 48'h0000_0001_0040);
    join_none
    repeat (20) @(posedge pclk);
    note(q_m.size() == 1 && q_rsp.size() == 1, "ordering");
    hold_bresp <= 1'b0;
    wait fork;
    drain();
    // odd half of a 64-bit window and an unused index are dropped
    in_op(1'b1, 1'b0, 3'h1, 64'h0000_0000_0000_0010, 0);
    in_op(1'b0, 1'b0, 3'h3, 64'h0000_0000_0000_0010, 0);
    in_op(1'b1, 1'b0, 3'h2, 64'h0000_0000_0000_0FFC, 12);
    drain();
    // interrupt: masked, raised, cleared by writing one
    rd(ST, 32'h7);
    cmp_reg(32'(irq), 32'h0);
    apb(1'b1, xlate_pkg::MASK_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    cmp_reg(32'(irq), 32'h1);
    apb(1'b1, ST, 32'h4);
    repeat (2) @(posedge pclk);
    cmp_reg(32'(irq), 32'h0);
    rd(ST, 32'h3);
    print_verdict();
  end
endmodule
